// [dhp_bus_asserts.sv]
// Checker on the port bus joining host and controller.
// Assumes it sits beside the interface in the testbench.
`timescale 1ns/10ps
`default_nettype none
module dhp_bus_asserts #(
  parameter logic [15:0] BASE = dhp_pkg::BASE_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioRdData,
  input wire logic intrReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [2:0] ofs;
  assign ofs = ioAddr[2:0];
  property p_in_block; (ioWr || ioRd) |-> ioAddr[15:3] == BASE[15:3]; endproperty
  a_in_block: assert property (p_in_block) else $error("access outside block");
  property p_spare; ioRd |=> ioRdData[5:0] == 6'h00; endproperty
  a_spare: assert property (p_spare) else $error("spare status bits set");
  property p_quiet; !ioRd |=> ioRdData == 8'h00; endproperty
  a_quiet: assert property (p_quiet) else $error("read data without read");
  property p_intr_bit; ioRd && ofs == 3'h0 |=> ioRdData[6] == $past(intrReq); endproperty
  a_intr_bit: assert property (p_intr_bit) else $error("status bit 6 wrong");
  property p_go_busy; ioWr && ofs == 3'h6 ##[1:4] ioRd && ofs == 3'h0 |=> ioRdData[7]; endproperty
  a_go_busy: assert property (p_go_busy) else $error("busy not set after start");
  property p_order; ioWr && ofs == 3'h0 |=> ioWr && ofs == 3'h2 ##1 ioWr && ofs == 3'h4 ##1 ioWr && ofs == 3'h6;
  endproperty
  a_order: assert property (p_order) else $error("pointer order broken");
  property p_hold; intrReq && !(ioWr && ofs == 3'h7) |=> intrReq; endproperty
  a_hold: assert property (p_hold) else $error("interrupt level dropped");
  property p_ack; ioWr && ofs == 3'h7 |=> !intrReq; endproperty
  a_ack: assert property (p_ack) else $error("interrupt not cleared");
  property p_ptr_hi; ioWr && ofs == 3'h4 |-> ioWrData[7:4] == 4'h0; endproperty
  a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high byte not padded");
  c_go: cover property (ioWr && ofs == 3'h6);
  c_intr: cover property ($rose(intrReq));
  c_ack: cover property (ioWr && ofs == 3'h7);
endmodule : dhp_bus_asserts
`default_nettype wire

// [dhp_device.sv]
// Controller end: port block decode, pointer, start byte, busy and interrupt.
// Assumes a firmware side that fetches the parameter block and reports done.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Decode eight consecutive ports at jumpered base
// - Status bit 7 shows operation busy
// - Status bit 6 shows interrupt driven
// - Status bits 5-0 unassigned, read zero
// - Host polls busy before new command
// - Host writes pointer bytes 0,2,4 in order
// - Pointer bytes form 20-bit parameter block address
// - Host writes start only after pointer
// - Polling host waits busy clear, reads status
// - Interrupted host checks bit 6 first
// - Write to offset seven drops interrupt
// - Firmware uses block, reports result
// - Bus master/slave, 16-bit data, 20-bit address
// - Jumpered 8/16-bit decode, default 90h
// - Level interrupt, one of eight levels
// - Bus init reset jumper-selectable
// - Offsets 0,2,4 load bits 0-7,8-15,16-19
// - Start byte: bit7 interrupt enable, bit6 wide
// - Offset seven write clears status bit 6
module dhp_device #(
  parameter logic [15:0] BASE = dhp_pkg::BASE_DEFAULT,
  parameter bit WIDE_DECODE = 1'b0,
  parameter bit INIT_RESET_EN = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic busInit,
  // Host side
  dhp_if.device port,
  // Firmware side
  output logic startPulse,
  output logic [dhp_pkg::PTR_W-1:0] cpbAddr,
  output logic intrEnable,
  output logic wideWords,
  input wire logic opDone,
  input wire logic [2:0] intrLevelSel,
  output logic [7:0] intrLines
);
  typedef enum logic {
    OP_IDLE = 1'b0,
    OP_BUSY = 1'b1
  } dhp_op_e;
  // Port decode
  logic hit;
  logic rst;
  logic [2:0] ofs;
  logic wrHit;
  logic wrPtrLo;
  logic wrPtrMid;
  logic wrPtrHi;
  logic wrGo;
  logic wrIntClr;
  logic rdStatus;
  logic opEnd;
  // Pointer state
  logic [dhp_pkg::PTR_W-1:0] ptr;
  logic [dhp_pkg::PTR_W-1:0] next_ptr;
  // Operation state
  dhp_op_e opState;
  dhp_op_e next_opState;
  logic busy;
  logic ien;
  logic next_ien;
  logic wide;
  logic next_wide;
  logic go;
  logic next_go;
  // Interrupt state
  logic intr;
  logic next_intr;
  logic [7:0] lines;
  wire logic [7:0] next_lines;
  // Read data state
  logic [7:0] rdData;
  logic [7:0] next_rdData;

  assign rst = reset | (INIT_RESET_EN & busInit);
  assign ofs = port.ioAddr[2:0];
  always_comb begin
    if (WIDE_DECODE) begin
      hit = (port.ioAddr[15:3] == BASE[15:3]);
    end else begin
      hit = (port.ioAddr[7:3] == BASE[7:3]);
    end
  end
  assign wrHit = port.ioWr & hit;
  assign wrPtrLo = wrHit & (ofs == dhp_pkg::OFS_PTR_LO);
  assign wrPtrMid = wrHit & (ofs == dhp_pkg::OFS_PTR_MID);
  assign wrPtrHi = wrHit & (ofs == dhp_pkg::OFS_PTR_HI);
  assign wrGo = wrHit & (ofs == dhp_pkg::OFS_GO);
  assign wrIntClr = wrHit & (ofs == dhp_pkg::OFS_INT_CLR);
  assign rdStatus = port.ioRd & hit & (ofs == dhp_pkg::OFS_STATUS);
  assign busy = (opState == OP_BUSY);
  assign opEnd = opDone & busy;

  // Pointer bytes
  always_comb begin
    next_ptr = ptr;
    if (wrPtrLo) begin
      next_ptr[7:0] = port.ioWrData;
    end
    if (wrPtrMid) begin
      next_ptr[15:8] = port.ioWrData;
    end
    if (wrPtrHi) begin
      next_ptr[19:16] = port.ioWrData[3:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr <= dhp_pkg::PTR_RESET;
    end else begin
      ptr <= next_ptr;
    end
  end

  // Start byte and busy
  always_comb begin
    next_opState = opState;
    next_ien = ien;
    next_wide = wide;
    next_go = 1'b0;
    if (wrGo) begin
      next_ien = port.ioWrData[dhp_pkg::BIT_IEN];
      next_wide = port.ioWrData[dhp_pkg::BIT_WIDE];
      next_go = 1'b1;
    end
    unique case (opState)
      OP_IDLE: begin
        if (wrGo) begin
          next_opState = OP_BUSY;
        end
      end
      OP_BUSY: begin
        if (opDone) begin
          next_opState = OP_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opState <= OP_IDLE;
      ien <= 1'b0;
      wide <= 1'b0;
      go <= 1'b0;
    end else begin
      opState <= next_opState;
      ien <= next_ien;
      wide <= next_wide;
      go <= next_go;
    end
  end

  // Interrupt level, set beats clear
  always_comb begin
    next_intr = intr;
    if (wrIntClr) begin
      next_intr = 1'b0;
    end
    if (opEnd && ien) begin
      next_intr = 1'b1;
    end
  end
  for (genvar lvl = 0; lvl < 8; lvl++) begin : gen_level
    assign next_lines[lvl] = next_intr & (intrLevelSel == 3'(lvl));
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intr <= 1'b0;
      lines <= 8'h00;
    end else begin
      intr <= next_intr;
      lines <= next_lines;
    end
  end

  // Status read, one cycle only
  always_comb begin
    next_rdData = 8'h00;
    if (rdStatus) begin
      next_rdData[dhp_pkg::BIT_BUSY] = busy;
      next_rdData[dhp_pkg::BIT_INTR] = intr;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= dhp_pkg::STATUS_RESET;
    end else begin
      rdData <= next_rdData;
    end
  end

  // Outputs straight from flops
  assign port.ioRdData = rdData;
  assign port.intrReq = intr;
  assign startPulse = go;
  assign cpbAddr = ptr;
  assign intrEnable = ien;
  assign wideWords = wide;
  assign intrLines = lines;
endmodule : dhp_device
`default_nettype wire

// [dhp_host.sv]
// Host end: sequences poll, pointer writes, start, and interrupt acknowledge.
// Assumes software drives a small register port with one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module dhp_host #(
  parameter logic [15:0] BASE = dhp_pkg::BASE_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Software register port
  input wire logic [1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Device side
  dhp_if.host port
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_POLL = 4'h1, S_WAIT = 4'h3, S_LO = 4'h2, S_MID = 4'h6,
    S_HI = 4'h7, S_GO = 4'h5, S_RUN = 4'h4, S_CHK = 4'hC, S_CWAIT = 4'hD, S_ACK = 4'hF
  } dhp_state_e;
  dhp_state_e state, next_state;
  logic [19:0] ptr, next_ptr;
  logic [7:0] cmd, next_cmd, last, next_last;
  logic done, next_done, mine, next_mine;
  logic [15:0] addr, next_addr;
  logic [7:0] wd, next_wd;
  logic wr, next_wr, rd, next_rd;
  logic [31:0] rdq, next_rdq;
  always_comb begin
    next_state = state;
    next_ptr = ptr;
    next_cmd = cmd;
    next_last = last;
    next_done = done;
    next_mine = mine;
    next_addr = addr;
    next_wd = wd;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_rdq = 32'h00000000;
    if (regWr && regAddr == dhp_pkg::HC_PTR) next_ptr = regWrData[19:0];
    if (regWr && regAddr == dhp_pkg::HC_CMD) next_cmd = regWrData[7:0];
    if (regRd) begin
      unique case (regAddr)
        dhp_pkg::HC_PTR: next_rdq = {12'h000, ptr};
        dhp_pkg::HC_STATUS: next_rdq = {28'h0000000, port.intrReq, mine, done, state == S_IDLE};
        dhp_pkg::HC_LAST: next_rdq = {24'h000000, last};
        default: next_rdq = {24'h000000, cmd};
      endcase
    end
    unique case (state)
      S_IDLE: begin
        if (regWr && regAddr == dhp_pkg::HC_CMD && regWrData[dhp_pkg::HC_GO_BIT]) begin
          next_done = 1'b0;
          next_state = S_POLL;
        end else if (port.intrReq && !wr) begin
          next_state = S_CHK;
        end
      end
      S_POLL: begin
        next_addr = BASE + 16'(dhp_pkg::OFS_STATUS);
        next_rd = 1'b1;
        next_state = S_WAIT;
      end
      S_WAIT: next_state = S_LO;
      S_LO: begin
        if (port.ioRdData[dhp_pkg::BIT_BUSY]) begin
          next_state = S_POLL;
        end else begin
          next_addr = BASE + 16'(dhp_pkg::OFS_PTR_LO);
          next_wd = ptr[7:0];
          next_wr = 1'b1;
          next_state = S_MID;
        end
      end
      S_MID: begin
        next_addr = BASE + 16'(dhp_pkg::OFS_PTR_MID);
        next_wd = ptr[15:8];
        next_wr = 1'b1;
        next_state = S_HI;
      end
      S_HI: begin
        next_addr = BASE + 16'(dhp_pkg::OFS_PTR_HI);
        next_wd = {4'h0, ptr[19:16]};
        next_wr = 1'b1;
        next_state = S_GO;
      end
      S_GO: begin
        next_addr = BASE + 16'(dhp_pkg::OFS_GO);
        next_wd = cmd;
        next_wr = 1'b1;
        next_state = S_RUN;
      end
      S_RUN: begin
        next_addr = BASE + 16'(dhp_pkg::OFS_STATUS);
        next_rd = 1'b1;
        next_state = S_CHK;
      end
      S_CHK: begin
        next_addr = BASE + 16'(dhp_pkg::OFS_STATUS);
        next_rd = 1'b1;
        next_state = S_CWAIT;
      end
      S_CWAIT: next_state = S_ACK;
      S_ACK: begin
        next_last = port.ioRdData;
        next_mine = port.ioRdData[dhp_pkg::BIT_INTR];
        if (port.ioRdData[dhp_pkg::BIT_INTR]) begin
          next_addr = BASE + 16'(dhp_pkg::OFS_INT_CLR);
          next_wr = 1'b1;
          next_done = 1'b1;
          next_state = S_IDLE;
        end else if (!port.ioRdData[dhp_pkg::BIT_BUSY]) begin
          next_done = 1'b1;
          next_state = S_IDLE;
        end else begin
          next_state = S_CHK;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      ptr <= 20'h00000;
      cmd <= 8'h00;
      last <= 8'h00;
      done <= 1'b0;
      mine <= 1'b0;
      addr <= 16'h0000;
      wd <= 8'h00;
      wr <= 1'b0;
      rd <= 1'b0;
      rdq <= 32'h00000000;
    end else begin
      state <= next_state;
      ptr <= next_ptr;
      cmd <= next_cmd;
      last <= next_last;
      done <= next_done;
      mine <= next_mine;
      addr <= next_addr;
      wd <= next_wd;
      wr <= next_wr;
      rd <= next_rd;
      rdq <= next_rdq;
    end
  end
  assign port.ioAddr = addr;
  assign port.ioWrData = wd;
  assign port.ioWr = wr;
  assign port.ioRd = rd;
  assign regRdData = rdq;
endmodule : dhp_host
`default_nettype wire

// [dhp_if.sv]
// Bus I/O cycle between host and controller port block, plus level interrupt.
// Assumes one clock; strobes are one cycle, read data the cycle after.
`timescale 1ns/10ps
`default_nettype none
interface dhp_if;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData;
  logic ioWr;
  logic ioRd;
  logic [7:0] ioRdData;
  logic intrReq;
  modport device (input ioAddr, ioWrData, ioWr, ioRd, output ioRdData, intrReq);
  modport host (output ioAddr, ioWrData, ioWr, ioRd, input ioRdData, intrReq);
endinterface : dhp_if
`default_nettype wire

// [dhp_pkg.sv]
// Shared constants for the host command port: port offsets, fields, resets.
// Assumes one 250 MHz clock and active-high asynchronous reset everywhere.
package dhp_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PTR_W = 20;
  localparam logic [2:0] OFS_STATUS = 3'h0;
  localparam logic [2:0] OFS_PTR_LO = 3'h0;
  localparam logic [2:0] OFS_PTR_MID = 3'h2;
  localparam logic [2:0] OFS_PTR_HI = 3'h4;
  localparam logic [2:0] OFS_GO = 3'h6;
  localparam logic [2:0] OFS_INT_CLR = 3'h7;
  localparam int BIT_BUSY = 7;
  localparam int BIT_INTR = 6;
  localparam int BIT_IEN = 7;
  localparam int BIT_WIDE = 6;
  localparam logic [15:0] BASE_DEFAULT = 16'h0090;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RESET = 20'h00000;
  // Host controller register offsets
  localparam logic [1:0] HC_CMD = 2'h0;
  localparam logic [1:0] HC_PTR = 2'h1;
  localparam logic [1:0] HC_STATUS = 2'h2;
  localparam logic [1:0] HC_LAST = 2'h3;
  localparam int HC_GO_BIT = 0;
  localparam int HC_ACK_BIT = 1;
  localparam int HC_POLL_BIT = 2;
endpackage : dhp_pkg

// [tb_disk_ctrl_host_command_port.sv]
// Testbench: host and controller joined, driven from software port.
// Assumes one 250 MHz clock and active-high reset.
`timescale 1ns/10ps
`default_nettype none
module tb_disk_ctrl_host_command_port;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic busInit = 1'b0;
  logic opDone = 1'b0;
  logic [2:0] intrLevelSel = 3'h5;
  logic [1:0] regAddr = 2'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic [31:0] rdv;
  logic startPulse;
  logic intrEnable;
  logic wideWords;
  logic [19:0] cpbAddr;
  logic [7:0] intrLines;
  int nFail = 0;
  int numChecks = 0;
  dhp_if bus();
  dhp_device dhp_device_i (.clk(clk), .reset(reset), .busInit(busInit), .port(bus), .startPulse(startPulse),
    .cpbAddr(cpbAddr), .intrEnable(intrEnable), .wideWords(wideWords), .opDone(opDone),
    .intrLevelSel(intrLevelSel), .intrLines(intrLines));
  dhp_host dhp_host_i (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .port(bus));
  dhp_bus_asserts dhp_bus_asserts_i (.clk(clk), .reset(reset), .ioAddr(bus.ioAddr), .ioWrData(bus.ioWrData),
    .ioWr(bus.ioWr), .ioRd(bus.ioRd), .ioRdData(bus.ioRdData), .intrReq(bus.intrReq));
  always #2 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic regWrite(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : regWrite
  task automatic regRead(input logic [1:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdData;
  endtask : regRead
  task automatic pulseDone;
    repeat (10) @(posedge clk);
    opDone <= 1'b1;
    @(posedge clk);
    opDone <= 1'b0;
  endtask : pulseDone
  task automatic launch(input logic [19:0] ptr, input logic [7:0] cmd);
    regWrite(dhp_pkg::HC_PTR, {12'h000, ptr});
    regWrite(dhp_pkg::HC_CMD, {24'h000000, cmd});
    for (int i = 0; i < 100 && startPulse !== 1'b1; i++) @(negedge clk);
    chk("start", startPulse, 1'b1);
    chk("ptr", cpbAddr, ptr);
    chk("ien", intrEnable, cmd[7]);
    chk("wide", wideWords, cmd[6]);
    regRead(dhp_pkg::HC_PTR);
    chk("ptrreg", rdv, {12'h000, ptr});
    regRead(dhp_pkg::HC_CMD);
    chk("cmdreg", rdv, {24'h000000, cmd});
  endtask : launch
  task automatic waitDone;
    for (int i = 0; i < 40; i++) begin
      regRead(dhp_pkg::HC_STATUS);
      if (rdv[1] === 1'b1) break;
    end
    chk("done", rdv[1], 1'b1);
  endtask : waitDone
  task automatic testPolled;
    launch(20'hB7D29, 8'h41);
    repeat (6) @(posedge clk);
    regRead(dhp_pkg::HC_LAST);
    chk("busy", rdv, 32'h80);
    pulseDone();
    waitDone();
    regRead(dhp_pkg::HC_LAST);
    chk("last", rdv, 32'h00);
    chk("noint", bus.intrReq, 1'b0);
  endtask : testPolled
  task automatic testIntr;
    launch(20'h0F00F, 8'h81);
    pulseDone();
    @(negedge clk);
    chk("lines", intrLines, 8'h20);
    chk("intr", bus.intrReq, 1'b1);
    waitDone();
    chk("mine", rdv[2], 1'b1);
    regRead(dhp_pkg::HC_LAST);
    chk("last", rdv, 32'h40);
    chk("linesoff", intrLines, 8'h00);
    chk("introff", bus.intrReq, 1'b0);
  endtask : testIntr
  task automatic testInit;
    pulseDone();
    repeat (3) @(negedge clk);
    chk("idledone", bus.intrReq, 1'b0);
    @(posedge clk);
    busInit <= 1'b1;
    @(posedge clk);
    busInit <= 1'b0;
    @(negedge clk);
    chk("initptr", cpbAddr, 20'h00000);
    chk("initien", intrEnable, 1'b0);
  endtask : testInit
  task automatic testReset;
    launch(20'h12345, 8'hC1);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("rstptr", cpbAddr, 20'h00000);
    chk("rstien", intrEnable, 1'b0);
    regRead(dhp_pkg::HC_STATUS);
    chk("rstidle", rdv[0], 1'b1);
  endtask : testReset
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : giveVerdict
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    testPolled();
    testIntr();
    testInit();
    testReset();
    giveVerdict();
  end
  initial begin
    #20000;
    nFail++;
    giveVerdict();
  end
endmodule : tb_disk_ctrl_host_command_port
`default_nettype wire
